// ---- rtl/cmd_status_engine.sv ----
// common command interpreter with status registers behind an ahb-lite slave
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
// Behaviour
// R1 - clear-status zeroes event status, status change register and error queue
// R2 - clear-status also cancels a pending operation-complete request
// R3 - event-status-enable set loads the argument into the enable mask
// R4 - event-status-enable query answers the mask in decimal, mask unchanged
// R5 - event-status query answers the register in decimal, then clears it
// R6 - identification query answers model, serial and firmware as ascii text
// R7 - learn query answers a value that, sent back, restores the setup
// R8 - operation-complete sets its event bit once pending operations finish
// R9 - operation-complete query waits for pending operations, then answers 1
// R10 - options query reports the fitted options
// R11 - protected data stored only with calibration switch enabled, else error
// R12 - protected data over 64 bytes raises an execution error
// R13 - protected data query answers the stored byte string
// R14 - save copies setup to save area, recall restores it
// R15 - reset returns power-up state but leaves automatic triggering stopped
// R16 - service-request-enable set loads the argument into its mask
// R17 - service-request-enable query answers the mask
// R18 - commands run one at a time; a command while busy is refused
// R19 - wait-to-continue blocks further commands until earlier ones completed
// R20 - status-byte query answers the status byte without a serial poll
// R21 - masks are eight bits; arguments above 255 raise an execution error
module cmd_status_engine
	import cmd_status_pkg::*;
#(
	parameter int EQ_DEPTH = 4,
	parameter int IDN_LEN = 16,
	// identity text is arbitrary
	parameter logic [8*IDN_LEN-1:0] IDN_STR = "CSE-1,000000,1.0"
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire dev_in_t dev_in,
	output dev_out_t dev_out
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [1:0] dec_len(input logic [7:0] v);
		dec_len = (v >= 8'd100) ? 2'd3 : (v >= 8'd10) ? 2'd2 : 2'd1;
	endfunction

	function automatic logic [7:0] dec_char(input logic [7:0] v, input logic [1:0] i);
		logic [7:0] d;
		logic [1:0] pos;
		d = 8'h00;
		pos = i + 2'd3 - dec_len(v);
		unique case (pos)
			2'd0: d = v / 8'd100;
			2'd1: d = (v / 8'd10) % 8'd10;
			default: d = v % 8'd10;
		endcase
		dec_char = CHR_0 + d;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	state_t state_r;
	logic wait_q_r;
	logic [7:0] esr_r;
	logic [7:0] ese_r;
	logic [7:0] sre_r;
	logic [7:0] instrument_status_change_register_r;
	logic [7:0] setup_r;
	logic [7:0] save_r;
	logic opc_pend_r;
	logic [7:0] pud_mem_r [PUD_MAX];
	logic [7:0] stage_r [PUD_MAX];
	logic [6:0] pud_len_r;
	logic [6:0] stage_cnt_r;
	logic stage_ovf_r;
	logic [7:0] eq_mem_r [EQ_DEPTH];
	logic [$clog2(EQ_DEPTH+1)-1:0] eq_cnt_r;
	resp_kind_t resp_kind_r;
	logic [7:0] resp_val_r;
	logic [6:0] resp_idx_r;
	logic [6:0] resp_len_r;
	logic resp_avail_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic addr_ok;
	logic rd_go;
	logic cmd_go;
	logic cmd_run;
	logic cmd_refused;
	opcode_t op;
	logic [15:0] arg;
	logic arg_bad;
	logic [7:0] arg8;

	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign rd_go = addr_ok && !hwrite;
	assign cmd_go = wr_pend_r && (wr_addr_r == ADDR_CMD);
	assign cmd_run = cmd_go && (state_r == ST_IDLE);
	assign cmd_refused = cmd_go && (state_r != ST_IDLE); // R18 R19
	assign op = opcode_t'(hwdata[CMD_OP_LSB +: 8]);
	assign arg = hwdata[CMD_ARG_LSB +: 16];
	assign arg_bad = arg > ARG_MAX; // R21
	assign arg8 = arg[7:0];
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	// ----------------------------------------
	// status byte
	// ----------------------------------------
	logic [7:0] stb_base;
	logic [7:0] stb;
	logic ops_done;

	assign ops_done = !dev_in.ops_busy;

	always_comb begin
		stb_base = 8'h00;
		stb_base[STB_ISC] = |instrument_status_change_register_r;
		stb_base[STB_MAV] = resp_avail_r;
		stb_base[STB_ESB] = |(esr_r & ese_r);
		stb = stb_base;
		stb[STB_MSS] = |(stb_base & sre_r);
	end

	assign dev_out.srq = stb[STB_MSS];
	assign dev_out.setup = setup_r;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic is_query;
	logic exe_err;
	logic cme_err;
	logic qye_err;
	logic [7:0] err_code;
	logic err_push;

	always_comb begin
		is_query = 1'b0;
		exe_err = 1'b0;
		cme_err = 1'b0;
		if (cmd_run) begin
			unique case (op)
				OP_ESE_Q, OP_ESR_Q, OP_IDN_Q, OP_LRN_Q, OP_OPT_Q, OP_PUD_Q,
				OP_SRE_Q, OP_STB_Q:
					is_query = 1'b1;
				OP_ESE, OP_SRE, OP_SETUP, OP_PUD_BYTE:
					exe_err = arg_bad; // R21
				OP_PUD_END:
					exe_err = !dev_in.cal_sw_en || stage_ovf_r; // R11 R12
				OP_CLS, OP_OPC, OP_OPC_Q, OP_PUD_BEGIN, OP_RCL, OP_RST,
				OP_SAV, OP_WAI: ;
				default:
					cme_err = 1'b1;
			endcase
		end
		cme_err = cme_err || cmd_refused;
	end

	// a new query discards an unread answer
	assign qye_err = is_query && resp_avail_r;
	assign err_push = exe_err || cme_err || qye_err || dev_in.dev_err;

	always_comb begin
		err_code = ERR_DDE;
		if (cme_err)
			err_code = ERR_CME;
		else if (exe_err)
			err_code = ERR_EXE;
		else if (qye_err)
			err_code = ERR_QYE;
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			wait_q_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (cmd_run && (op == OP_WAI || op == OP_OPC_Q)) begin
						state_r <= ST_WAIT; // R18 R19
						wait_q_r <= (op == OP_OPC_Q);
					end
				end
				ST_WAIT: begin
					if (ops_done)
						state_r <= ST_IDLE; // R9 R19
				end
			endcase
		end
	end

	// ----------------------------------------
	// event status and operation complete
	// ----------------------------------------
	logic [7:0] esr_set;
	logic esr_clr;
	logic opc_fire;

	assign opc_fire = opc_pend_r && ops_done;
	assign esr_clr = cmd_run && (op == OP_CLS || op == OP_ESR_Q); // R1 R5

	always_comb begin
		esr_set = 8'h00;
		esr_set[ESR_OPC] = opc_fire; // R8
		esr_set[ESR_QYE] = qye_err;
		esr_set[ESR_DDE] = dev_in.dev_err;
		esr_set[ESR_EXE] = exe_err;
		esr_set[ESR_CME] = cme_err;
	end

	// set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			esr_r <= 8'h00;
		else
			esr_r <= (esr_clr ? 8'h00 : esr_r) | esr_set; // R1 R5
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opc_pend_r <= 1'b0;
		end else begin
			if (cmd_run && (op == OP_CLS || op == OP_RST))
				opc_pend_r <= 1'b0; // R2
			else if (cmd_run && op == OP_OPC)
				opc_pend_r <= 1'b1; // R8
			else if (opc_fire)
				opc_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instrument_status_change_register_r <= 8'h00;
		end else begin
			if (cmd_run && op == OP_CLS)
				instrument_status_change_register_r <= dev_in.isc_event; // R1
			else
				instrument_status_change_register_r <= instrument_status_change_register_r | dev_in.isc_event;
		end
	end

	// ----------------------------------------
	// masks and setup
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ese_r <= MASK_RST;
			sre_r <= MASK_RST;
		end else if (cmd_run && !arg_bad) begin
			if (op == OP_ESE)
				ese_r <= arg8; // R3
			if (op == OP_SRE)
				sre_r <= arg8; // R16
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup_r <= SETUP_RST;
			save_r <= SETUP_RST;
		end else if (cmd_run) begin
			unique case (op)
				OP_SAV: save_r <= setup_r; // R14
				OP_RCL: setup_r <= save_r; // R14
				OP_RST: begin
					setup_r <= SETUP_RST; // R15
					setup_r[SETUP_AUTOTRIG] <= 1'b0; // R15
				end
				OP_SETUP: if (!arg_bad) setup_r <= arg8; // R7
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// protected user data
	// ----------------------------------------
	logic pud_commit;

	assign pud_commit = cmd_run && op == OP_PUD_END && !exe_err; // R11 R12

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_cnt_r <= 7'd0;
			stage_ovf_r <= 1'b0;
		end else if (cmd_run && op == OP_PUD_BEGIN) begin
			stage_cnt_r <= 7'd0;
			stage_ovf_r <= 1'b0;
		end else if (cmd_run && op == OP_PUD_BYTE && !arg_bad) begin
			if (stage_cnt_r == 7'(PUD_MAX))
				stage_ovf_r <= 1'b1; // R12
			else
				stage_cnt_r <= stage_cnt_r + 7'd1;
		end
	end

	always_ff @(posedge hclk) begin
		if (cmd_run && op == OP_PUD_BYTE && !arg_bad && stage_cnt_r < 7'(PUD_MAX))
			stage_r[stage_cnt_r[5:0]] <= arg8;
	end

	// storage stands in for the nonvolatile area
	always_ff @(posedge hclk) begin
		if (pud_commit) begin
			for (int i = 0; i < PUD_MAX; i++)
				pud_mem_r[i] <= stage_r[i]; // R11
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pud_len_r <= 7'd0;
		else if (pud_commit)
			pud_len_r <= stage_cnt_r; // R11
	end

	// ----------------------------------------
	// error queue
	// ----------------------------------------
	logic eq_pop;

	assign eq_pop = rd_go && haddr[7:0] == ADDR_ERRQ && eq_cnt_r != '0;

	// oldest entry at index 0; a full queue drops the newest error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eq_cnt_r <= '0;
			for (int i = 0; i < EQ_DEPTH; i++)
				eq_mem_r[i] <= 8'h00;
		end else if (cmd_run && op == OP_CLS) begin
			eq_cnt_r <= '0; // R1
		end else begin
			if (eq_pop) begin
				for (int i = 0; i < EQ_DEPTH - 1; i++)
					eq_mem_r[i] <= eq_mem_r[i+1];
			end
			if (err_push && eq_cnt_r != EQ_DEPTH)
				eq_mem_r[eq_cnt_r - (eq_pop ? 1 : 0)] <= err_code;
			if (eq_pop && !(err_push && eq_cnt_r != EQ_DEPTH))
				eq_cnt_r <= eq_cnt_r - 1'b1;
			else if (!eq_pop && err_push && eq_cnt_r != EQ_DEPTH)
				eq_cnt_r <= eq_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------
	// response stream
	// ----------------------------------------
	logic resp_load;
	resp_kind_t load_kind;
	logic [7:0] load_val;
	logic [7:0] resp_byte;
	logic resp_pop;

	assign resp_load = is_query || (state_r == ST_WAIT && wait_q_r && ops_done);
	assign resp_pop = rd_go && haddr[7:0] == ADDR_RESP && resp_avail_r;

	always_comb begin
		load_kind = RK_DEC;
		load_val = 8'h00;
		if (state_r == ST_WAIT) begin
			load_val = 8'h01; // R9
		end else begin
			unique case (op)
				OP_ESE_Q: load_val = ese_r; // R4
				OP_ESR_Q: load_val = esr_r; // R5
				OP_IDN_Q: load_kind = RK_IDN; // R6
				OP_LRN_Q: load_val = setup_r; // R7
				OP_OPT_Q: load_val = dev_in.opt_fitted; // R10
				OP_PUD_Q: load_kind = RK_PUD; // R13
				OP_SRE_Q: load_val = sre_r; // R17
				OP_STB_Q: load_val = stb; // R20
				default: ;
			endcase
		end
	end

	// every answer ends in a line feed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_kind_r <= RK_DEC;
			resp_val_r <= 8'h00;
			resp_idx_r <= 7'd0;
			resp_len_r <= 7'd0;
			resp_avail_r <= 1'b0;
		end else if (resp_load) begin
			resp_kind_r <= load_kind;
			resp_val_r <= load_val;
			resp_idx_r <= 7'd0;
			resp_avail_r <= 1'b1;
			unique case (load_kind)
				RK_IDN: resp_len_r <= 7'(IDN_LEN + 1);
				RK_PUD: resp_len_r <= pud_len_r + 7'd1;
				default: resp_len_r <= {5'd0, dec_len(load_val)} + 7'd1;
			endcase
		end else if (resp_pop) begin
			resp_idx_r <= resp_idx_r + 7'd1;
			if (resp_idx_r + 7'd1 == resp_len_r)
				resp_avail_r <= 1'b0;
		end
	end

	always_comb begin
		resp_byte = CHR_LF;
		if (resp_idx_r + 7'd1 != resp_len_r) begin
			unique case (resp_kind_r)
				RK_IDN: resp_byte = IDN_STR[8*(IDN_LEN-1-int'(resp_idx_r)) +: 8]; // R6
				RK_PUD: resp_byte = pud_mem_r[resp_idx_r[5:0]]; // R13
				default: resp_byte = dec_char(resp_val_r, resp_idx_r[1:0]);
			endcase
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_go) begin
			hrdata_r <= 32'h0000_0000;
			unique case (haddr[7:0])
				ADDR_CMD: hrdata_r[STATUS_BUSY_BIT] <= state_r != ST_IDLE;
				ADDR_RESP: hrdata_r[RESP_VALID_BIT:0] <= {resp_avail_r, resp_byte};
				ADDR_STATUS: begin
					hrdata_r[7:0] <= stb;
					hrdata_r[STATUS_ESR_LSB +: 8] <= esr_r;
					hrdata_r[STATUS_INSTRUMENT_STATUS_CHANGE_REGISTER_LSB +: 8] <= instrument_status_change_register_r;
					hrdata_r[STATUS_BUSY_BIT] <= state_r != ST_IDLE;
				end
				ADDR_ERRQ:
					hrdata_r[ERRQ_VALID_BIT:0] <= {eq_cnt_r != '0, eq_mem_r[0]};
				ADDR_SETUP: hrdata_r[7:0] <= setup_r;
				default: ;
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- shared/cmd_status_pkg.sv ----
// constants, opcodes and carrier types of the common command and status engine
`default_nettype none
package cmd_status_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_RESP = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_ERRQ = 8'h0c;
	localparam logic [7:0] ADDR_SETUP = 8'h10;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ARG_LSB = 8;
	localparam int RESP_VALID_BIT = 8;
	localparam int ERRQ_VALID_BIT = 8;
	localparam int STATUS_ESR_LSB = 8;
	localparam int STATUS_INSTRUMENT_STATUS_CHANGE_REGISTER_LSB = 16;
	localparam int STATUS_BUSY_BIT = 24;
	localparam int ESR_OPC = 0;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int STB_ISC = 0;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;
	localparam int SETUP_AUTOTRIG = 0;
	// ----------------------------------------
	// values and limits
	// ----------------------------------------
	localparam logic [7:0] SETUP_RST = 8'h01;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [15:0] ARG_MAX = 16'h00ff;
	localparam int PUD_MAX = 64;
	localparam logic [7:0] ERR_CME = 8'h01;
	localparam logic [7:0] ERR_EXE = 8'h02;
	localparam logic [7:0] ERR_QYE = 8'h03;
	localparam logic [7:0] ERR_DDE = 8'h04;
	localparam logic [7:0] CHR_LF = 8'h0a;
	localparam logic [7:0] CHR_0 = 8'h30;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [7:0] {
		OP_CLS = 8'h01, OP_ESE = 8'h02, OP_ESE_Q = 8'h03, OP_ESR_Q = 8'h04,
		OP_IDN_Q = 8'h05, OP_LRN_Q = 8'h06, OP_OPC = 8'h07, OP_OPC_Q = 8'h08,
		OP_OPT_Q = 8'h09, OP_PUD_BEGIN = 8'h0a, OP_PUD_BYTE = 8'h0b,
		OP_PUD_END = 8'h0c, OP_PUD_Q = 8'h0d, OP_RCL = 8'h0e, OP_RST = 8'h0f,
		OP_SAV = 8'h10, OP_SRE = 8'h11, OP_SRE_Q = 8'h12, OP_STB_Q = 8'h13,
		OP_WAI = 8'h14, OP_SETUP = 8'h15
	} opcode_t;
	typedef enum logic [1:0] {
		RK_DEC = 2'b00, RK_IDN = 2'b01, RK_PUD = 2'b10
	} resp_kind_t;
	typedef enum logic {
		ST_IDLE = 1'b0, ST_WAIT = 1'b1
	} state_t;
	typedef struct packed {
		logic ops_busy;
		logic dev_err;
		logic cal_sw_en;
		logic [7:0] opt_fitted;
		logic [7:0] isc_event;
	} dev_in_t;
	typedef struct packed {
		logic srq;
		logic [7:0] setup;
	} dev_out_t;
endpackage
`default_nettype wire

// ---- sim/common_command_status_engine_tb.sv ----
// self-checking bench for the command and status engine
`default_nettype none
module common_command_status_engine_tb
	import cmd_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [127:0] IDN_TXT = "TB-UNIT,00,2.1.0"; // arbitrary text
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic start = 1'b0, cal_en = 1'b0, err = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [7:0] isc = 8'h00;
	dev_in_t dev_in;
	dev_out_t dev_out;
	int mismatches = 0, total_checks = 0, cycles = 0;
	always #2.5 hclk = ~hclk;
	cmd_status_engine #(.IDN_STR(IDN_TXT)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .dev_in(dev_in), .dev_out(dev_out));
	device_side_model model (.hclk(hclk), .hresetn(hresetn), .start(start),
		.cal_en(cal_en), .err(err), .isc(isc), .dev_in(dev_in));
	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic print_verdict;
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chks(input string got, input string exp);
		total_checks++;
		if (got != exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; read data taken at the closing edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cmd(input opcode_t op, input logic [15:0] arg);
		bus(1'b1, ADDR_CMD, {8'h00, arg, op});
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic answer(input string exp);
		string s = "";
		for (int i = 0; i < 80; i++) begin
			bus(1'b0, ADDR_RESP, 32'h0);
			if (rd[RESP_VALID_BIT] !== 1'b1)
				break;
			s = {s, string'(rd[7:0])};
			if (rd[7:0] === CHR_LF)
				break;
		end
		chks(s, exp);
	endtask
	task automatic ask(input opcode_t op, input string exp);
		cmd(op, 16'h0000);
		answer(exp);
	endtask
	task automatic kick;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
	endtask
	task automatic pud(input int n, input logic [7:0] b);
		cmd(OP_PUD_BEGIN, 16'h0000);
		for (int i = 0; i < n; i++)
			cmd(OP_PUD_BYTE, {8'h00, b});
		cmd(OP_PUD_END, 16'h0000);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		reg_is(ADDR_SETUP, 32'hff, {24'h0, SETUP_RST});
		reg_is(ADDR_STATUS, 32'h1ffffff, 32'h0);
		reg_is(8'h40, 32'hffffffff, 32'h0);
		ask(OP_SRE_Q, "0\n");
	endtask
	task automatic t_ese;
		cmd(OP_ESE, 16'h00ff);
		ask(OP_ESE_Q, "255\n");
		ask(OP_ESE_Q, "255\n");
		cmd(OP_ESE, 16'h0100);
		ask(OP_ESE_Q, "255\n");
		reg_is(ADDR_ERRQ, 32'h1ff, 32'h102);
		ask(OP_ESR_Q, "16\n");
		ask(OP_ESR_Q, "0\n");
	endtask
	task automatic t_sre;
		cmd(OP_SRE, 16'h0010);
		cmd(OP_SRE_Q, 16'h0000);
		reg_is(ADDR_STATUS, 32'h50, 32'h50);
		chk(dev_out.srq, 1'b1);
		answer("16\n");
		@(posedge hclk);
		chk(dev_out.srq, 1'b0);
		cmd(OP_SRE, 16'h0000);
	endtask
	task automatic t_id;
		ask(OP_IDN_Q, {string'(IDN_TXT), "\n"});
		ask(OP_OPT_Q, "5\n");
	endtask
	task automatic t_isc;
		isc <= 8'h81;
		err <= 1'b1;
		@(posedge hclk);
		isc <= 8'h00;
		err <= 1'b0;
		reg_is(ADDR_STATUS, 32'hffff01, 32'h810801);
		ask(OP_STB_Q, "33\n");
		cmd(OP_CLS, 16'h0000);
		reg_is(ADDR_STATUS, 32'hffff00, 32'h0);
		reg_is(ADDR_ERRQ, 32'h100, 32'h0);
	endtask
	task automatic t_opc;
		kick;
		cmd(OP_OPC, 16'h0000);
		reg_is(ADDR_STATUS, 32'h100, 32'h0);
		repeat (8) @(posedge hclk);
		reg_is(ADDR_STATUS, 32'h100, 32'h100);
		ask(OP_ESR_Q, "1\n");
		kick;
		cmd(OP_OPC, 16'h0000);
		cmd(OP_CLS, 16'h0000);
		repeat (8) @(posedge hclk);
		reg_is(ADDR_STATUS, 32'h100, 32'h0);
	endtask
	task automatic t_setup;
		cmd(OP_SETUP, 16'h005a);
		ask(OP_LRN_Q, "90\n");
		cmd(OP_SAV, 16'h0000);
		cmd(OP_SETUP, 16'h0003);
		cmd(OP_RCL, 16'h0000);
		reg_is(ADDR_SETUP, 32'hff, 32'h5a);
		cmd(OP_SETUP, 16'h0000);
		cmd(OP_SETUP, 16'h005a);
		reg_is(ADDR_SETUP, 32'hff, 32'h5a);
		cmd(OP_SETUP, 16'h0100);
		reg_is(ADDR_SETUP, 32'hff, 32'h5a);
		reg_is(ADDR_ERRQ, 32'h1ff, 32'h102);
		ask(OP_ESR_Q, "16\n");
		cmd(OP_RST, 16'h0000);
		reg_is(ADDR_SETUP, 32'hff, {24'h0, SETUP_RST & 8'hfe});
	endtask
	task automatic t_busy;
		opcode_t ops[2] = '{OP_OPC_Q, OP_WAI};
		foreach (ops[i]) begin
			kick;
			cmd(ops[i], 16'h0000);
			reg_is(ADDR_STATUS, 32'h1000000, 32'h1000000);
			cmd(OP_SETUP, 16'h0022);
			repeat (8) @(posedge hclk);
			reg_is(ADDR_SETUP, 32'hff, 32'h0);
			reg_is(ADDR_ERRQ, 32'h1ff, 32'h101);
			if (ops[i] == OP_OPC_Q)
				answer("1\n");
			ask(OP_ESR_Q, "32\n");
		end
	endtask
	task automatic t_pud;
		string s = "";
		for (int i = 0; i < 64; i++)
			s = {s, "C"};
		cal_en <= 1'b0;
		pud(2, 8'h41);
		reg_is(ADDR_ERRQ, 32'h1ff, 32'h102);
		ask(OP_PUD_Q, "\n");
		cal_en <= 1'b1;
		pud(2, 8'h41);
		ask(OP_PUD_Q, "AA\n");
		pud(65, 8'h42);
		reg_is(ADDR_ERRQ, 32'h1ff, 32'h102);
		ask(OP_PUD_Q, "AA\n");
		pud(64, 8'h43);
		ask(OP_PUD_Q, {s, "\n"});
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_ese;
		t_sre;
		t_id;
		t_isc;
		t_opc;
		t_setup;
		t_busy;
		t_pud;
		print_verdict;
	end
endmodule
`default_nettype wire

// ---- sim/device_side_model.sv ----
// device side: pending operations, calibration switch, options and events
`default_nettype none
module device_side_model
	import cmd_status_pkg::*;
#(
	parameter int OPS_LEN = 6,
	parameter logic [7:0] OPT_BITS = 8'h05
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic cal_en,
	input wire logic err,
	input wire logic [7:0] isc,
	output var dev_in_t dev_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int left;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			left <= 0;
		else if (start)
			left <= OPS_LEN;
		else if (left > 0)
			left <= left - 1;
	end
	// one packed drive, so no field has two drivers
	assign dev_in = '{ops_busy: left > 0, dev_err: err, cal_sw_en: cal_en,
		opt_fitted: OPT_BITS, isc_event: isc};
endmodule
`default_nettype wire

// ---- sim/status_props.sv ----
// concurrent checks on the command and status engine ports
`default_nettype none
module status_props
	import cmd_status_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire dev_in_t dev_in,
	input wire dev_out_t dev_out
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// data phase tracking
	// ----------------------------------------
	logic ap_r, wr_r, busy_r;
	logic [7:0] ad_r;
	wire logic rd_ap = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	wire logic cmd_go = ap_r && wr_r && ad_r == ADDR_CMD && !busy_r;
	wire logic [7:0] op = hwdata[7:0];
	wire logic [15:0] arg = hwdata[23:8];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r <= 1'b0;
			wr_r <= 1'b0;
			ad_r <= 8'h00;
		end else begin
			ap_r <= hsel && hready && htrans == HTRANS_NONSEQ;
			wr_r <= hwrite;
			ad_r <= haddr[7:0];
		end
	end
	// busy is entered only by a command that was itself accepted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			busy_r <= 1'b0;
		else if (cmd_go && (op == OP_OPC_Q || op == OP_WAI))
			busy_r <= 1'b1;
		else if (busy_r && !dev_in.ops_busy)
			busy_r <= 1'b0;
	end
	ready_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("slave not ready or not okay");
	setup_load_a: assert property (cmd_go && op == OP_SETUP && arg <= ARG_MAX
		|=> dev_out.setup == $past(arg[7:0])) else $error("setup not loaded");
	setup_arg_a: assert property (cmd_go && op == OP_SETUP && arg > ARG_MAX
		|=> $stable(dev_out.setup)) else $error("setup took a bad argument");
	reset_trig_a: assert property (cmd_go && op == OP_RST
		|=> dev_out.setup == (SETUP_RST & 8'hfe)) else $error("reset left triggering on");
	busy_refuse_a: assert property (busy_r && ap_r && wr_r && ad_r == ADDR_CMD
		|=> $stable(dev_out.setup)) else $error("command ran while busy");
	setup_cause_a: assert property ($changed(dev_out.setup) |-> $past(cmd_go))
		else $error("setup changed without a command");
	sre_clear_a: assert property (cmd_go && op == OP_SRE && arg == 16'h0000
		|=> !dev_out.srq) else $error("service request with empty mask");
	rd_hold_a: assert property ($changed(hrdata) |-> $past(rd_ap))
		else $error("read data moved without a read");
	busy_flag_a: assert property (ap_r && !wr_r && ad_r == ADDR_STATUS
		|-> hrdata[STATUS_BUSY_BIT] == $past(busy_r)) else $error("busy flag wrong");
	cover property (cmd_go && op == OP_SETUP);
	cover property (busy_r && ap_r && wr_r);
	cover property (cmd_go && op == OP_RST);
endmodule
bind cmd_status_engine status_props props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.dev_in(dev_in), .dev_out(dev_out));
`default_nettype wire
